/* File: common/duty_pkg.sv */
`default_nettype none
package duty_pkg;

    // ------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_PERIOD_US = 1000;
    localparam int TICK_CYCLES = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Duty cycle figures, in ticks of one millisecond
    // ------------------------------------------------------------
    localparam int AIR_W = 16;
    localparam int OWED_W = 21;
    localparam logic [3:0] PAUSE_FACTOR = 4'hC;
    localparam int ALLOW_MAX_S = 30;
    localparam logic [AIR_W-1:0] ALLOW_MAX_MS = AIR_W'(ALLOW_MAX_S * 1000);
    localparam logic [AIR_W-1:0] ALLOW_RESET_MS = ALLOW_MAX_MS;
    localparam logic [AIR_W-1:0] AIR_ZERO = 16'h0000;
    localparam logic [AIR_W-1:0] AIR_SAT = 16'hFFFF;
    localparam logic [OWED_W-1:0] OWED_ZERO = 21'h000000;
    localparam logic [OWED_W-1:0] OWED_SAT = 21'h1FFFFF;

    // ------------------------------------------------------------
    // Channel plan and power table
    // ------------------------------------------------------------
    localparam int FREQ_W = 30;
    localparam logic [6:0] CHAN_FIRST = 7'h01;
    localparam logic [6:0] CHAN_LAST_LOW = 7'h0A;
    localparam logic [6:0] CHAN_HIGH = 7'h64;
    localparam logic [FREQ_W-1:0] FREQ_CH1_HZ = 30'h33D22E94;
    localparam logic [FREQ_W-1:0] CHAN_STEP_HZ = 30'h000061A8;
    localparam logic [FREQ_W-1:0] FREQ_HIGH_HZ = 30'h33D3E608;
    localparam logic [3:0] PWR_FIRST = 4'h1;
    localparam logic [3:0] PWR_LAST_LOW = 4'h5;
    localparam logic [3:0] PWR_LAST = 4'hA;
    localparam logic [4:0] DBM_RESET = 5'h0A;

    typedef enum logic {RATE_1200, RATE_19200} rate_t;

    typedef struct packed {
        logic [FREQ_W-1:0] freq_hz;
        rate_t rate;
        logic [4:0] power_dbm;
        logic pa_tx_en;
        logic pa_rx_en;
    } radio_cfg_t;

    localparam radio_cfg_t RADIO_CFG_RESET = '{
        freq_hz: FREQ_CH1_HZ,
        rate: RATE_1200,
        power_dbm: DBM_RESET,
        pa_tx_en: 1'b0,
        pa_rx_en: 1'b0
    };

endpackage : duty_pkg
`default_nettype wire

/* File: src/tick_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module tick_gen #(
    parameter int CYCLES = duty_pkg::TICK_CYCLES
) (
    input wire logic clock,   // System clock
    input wire logic reset_n, // Async reset, active low
    output logic tick_r       // One-cycle pulse per period
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_r;
    logic [CW-1:0] count_nxt;
    wire wrap = (count_r == LAST);

    assign count_nxt = wrap ? '0 : count_r + CW'(1);

    // Free running: never gated by sleep, so pause keeps elapsing
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_r <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            tick_r <= wrap;
        end
    end

endmodule : tick_gen
`default_nettype wire

/* File: src/radio_cfg_map.sv */
`timescale 1ns/1ns
`default_nettype none
module radio_cfg_map (
    input wire logic clock,              // System clock
    input wire logic reset_n,            // Async reset, active low
    input wire logic load,               // Apply channel and level
    input wire logic [6:0] channel,      // Channel number
    input wire logic [3:0] power_level,  // Power level 1..10
    output duty_pkg::radio_cfg_t cfg_r,  // Active radio settings
    output logic cfg_error_r             // Last load was rejected
);

    logic chan_low;
    logic chan_ok;
    logic pwr_ok;
    logic [duty_pkg::FREQ_W-1:0] low_freq;
    logic [4:0] dbm;
    duty_pkg::radio_cfg_t cfg_nxt;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign chan_low = (channel >= duty_pkg::CHAN_FIRST) && (channel <= duty_pkg::CHAN_LAST_LOW);
    assign chan_ok = chan_low || (channel == duty_pkg::CHAN_HIGH);
    assign pwr_ok = (power_level >= duty_pkg::PWR_FIRST) && (power_level <= duty_pkg::PWR_LAST);
    assign low_freq = duty_pkg::FREQ_CH1_HZ
        + duty_pkg::FREQ_W'(duty_pkg::CHAN_STEP_HZ * (channel - duty_pkg::CHAN_FIRST));

    assign dbm = (power_level == 4'h1) ? 5'h0A :
                 (power_level == 4'h2) ? 5'h0B :
                 (power_level == 4'h3) ? 5'h0C :
                 (power_level == 4'h4) ? 5'h0D :
                 (power_level == 4'h5) ? 5'h0E :
                 (power_level == 4'h6) ? 5'h12 :
                 (power_level == 4'h7) ? 5'h16 :
                 (power_level == 4'h8) ? 5'h18 :
                 (power_level == 4'h9) ? 5'h1A : 5'h1B;

    assign cfg_nxt.freq_hz = chan_low ? low_freq : duty_pkg::FREQ_HIGH_HZ;
    assign cfg_nxt.rate = chan_low ? duty_pkg::RATE_1200 : duty_pkg::RATE_19200;
    assign cfg_nxt.power_dbm = dbm;
    assign cfg_nxt.pa_tx_en = (power_level > duty_pkg::PWR_LAST_LOW);
    assign cfg_nxt.pa_rx_en = (power_level > duty_pkg::PWR_LAST_LOW);

    // Rejected loads keep the old settings so the radio never sees a bad tune
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg_r <= duty_pkg::RADIO_CFG_RESET;
            cfg_error_r <= 1'b0;
        end
        else if (load)
        begin
            if (chan_ok && pwr_ok)
                cfg_r <= cfg_nxt;
            cfg_error_r <= !(chan_ok && pwr_ok);
        end
    end

endmodule : radio_cfg_map
`default_nettype wire

/* File: src/tx_duty_cycle_governor.sv */
`timescale 1ns/1ns
`default_nettype none
module tx_duty_cycle_governor #(
    parameter int TICK_CYCLES = duty_pkg::TICK_CYCLES
) (
    input wire logic clock,                                // System clock, 250 MHz
    input wire logic reset_n,                              // Async reset, active low
    input wire logic pkt_req,                              // Packet waiting to be sent, level
    input wire logic tx_active,                            // Transceiver on air, level
    input wire logic sleep,                                // Module asleep, level
    input wire logic allow_load,                           // Take allow_ms, pulse
    input wire logic [duty_pkg::AIR_W-1:0] allow_ms,       // Requested airtime allowance
    input wire logic radio_load,                           // Take channel and level, pulse
    input wire logic [6:0] channel,                        // Channel number
    input wire logic [3:0] power_level,                    // Power level
    output logic tx_start_r,                               // Start packet, pulse
    output logic pkt_done_r,                               // Packet airtime booked, pulse
    output logic tx_hold_r,                                // Owed pause blocks sending
    output logic [duty_pkg::AIR_W-1:0] allow_r,            // Allowance in force
    output logic [duty_pkg::AIR_W-1:0] burst_air_r,        // Airtime used in this burst
    output logic [duty_pkg::OWED_W-1:0] owed_r,            // Pause still owed
    output duty_pkg::radio_cfg_t radio_cfg_r,              // Radio settings
    output logic radio_err_r                               // Last radio load rejected
);

    // ------------------------------------------------------------
    // Types and signals
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_TX, ST_HOLD} gov_state_t;

    gov_state_t state_r;
    gov_state_t state_nxt;
    logic tick;
    logic [duty_pkg::AIR_W-1:0] pkt_air_r;
    logic [duty_pkg::AIR_W-1:0] pkt_air_nxt;
    logic [duty_pkg::AIR_W-1:0] burst_air_nxt;
    logic [duty_pkg::AIR_W-1:0] allow_nxt;
    logic [duty_pkg::OWED_W-1:0] owed_nxt;
    logic tx_start_nxt;
    logic pkt_done_nxt;
    logic tx_hold_nxt;

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    tick_gen #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clock(clock),
        .reset_n(reset_n),
        .tick_r(tick)
    );

    // ------------------------------------------------------------
    // Channel and power mapping
    // ------------------------------------------------------------
    radio_cfg_map u_map (
        .clock(clock),
        .reset_n(reset_n),
        .load(radio_load),
        .channel(channel),
        .power_level(power_level),
        .cfg_r(radio_cfg_r),
        .cfg_error_r(radio_err_r)
    );

    // ------------------------------------------------------------
    // Allowance configuration
    // ------------------------------------------------------------
    wire allow_too_big = (allow_ms > duty_pkg::ALLOW_MAX_MS);
    wire [duty_pkg::AIR_W-1:0] allow_clamped = allow_too_big ? duty_pkg::ALLOW_MAX_MS : allow_ms;

    assign allow_nxt = allow_load ? allow_clamped : allow_r;

    // ------------------------------------------------------------
    // Airtime measurement
    // ------------------------------------------------------------
    wire on_air = (state_r == ST_TX) && tx_active;
    wire tx_end = (state_r == ST_TX) && !tx_active;
    wire pkt_air_full = (pkt_air_r == duty_pkg::AIR_SAT);

    // Starts at one so a partial tick is booked, never lost
    wire [duty_pkg::AIR_W-1:0] pkt_air_inc = pkt_air_full ? pkt_air_r : pkt_air_r + duty_pkg::AIR_W'(1);

    assign pkt_air_nxt = (state_r == ST_START) ? duty_pkg::AIR_W'(1) :
                         (on_air && tick) ? pkt_air_inc : pkt_air_r;

    // ------------------------------------------------------------
    // Pause obligation of the finished packet
    // ------------------------------------------------------------
    wire [duty_pkg::OWED_W+3:0] pkt_pause_wide = (duty_pkg::OWED_W + 4)'(pkt_air_r)
        * (duty_pkg::OWED_W + 4)'(duty_pkg::PAUSE_FACTOR);
    wire [duty_pkg::OWED_W+4:0] owed_sum_wide = (duty_pkg::OWED_W + 5)'(owed_r)
        + (duty_pkg::OWED_W + 5)'(pkt_pause_wide);
    wire owed_sum_ovf = (owed_sum_wide > (duty_pkg::OWED_W + 5)'(duty_pkg::OWED_SAT));
    wire [duty_pkg::OWED_W-1:0] owed_added = owed_sum_ovf ? duty_pkg::OWED_SAT
                                                          : owed_sum_wide[duty_pkg::OWED_W-1:0];

    // ------------------------------------------------------------
    // Pause elapsing
    // ------------------------------------------------------------
    // Decrement ignores sleep on purpose: pause counts in every state off air
    wire owed_zero = (owed_r == duty_pkg::OWED_ZERO);
    wire pause_step = tick && !on_air && !owed_zero;
    wire [duty_pkg::OWED_W-1:0] owed_dec = owed_r - duty_pkg::OWED_W'(1);

    assign owed_nxt = tx_end ? owed_added :
                      pause_step ? owed_dec : owed_r;

    // ------------------------------------------------------------
    // Burst accounting
    // ------------------------------------------------------------
    wire [duty_pkg::AIR_W:0] burst_sum_wide = (duty_pkg::AIR_W + 1)'(burst_air_r)
        + (duty_pkg::AIR_W + 1)'(pkt_air_r);
    wire [duty_pkg::AIR_W-1:0] burst_added = burst_sum_wide[duty_pkg::AIR_W] ? duty_pkg::AIR_SAT
                                                                             : burst_sum_wide[duty_pkg::AIR_W-1:0];

    // A fully paid pause opens a fresh burst
    wire burst_paid = owed_zero && (state_r != ST_TX) && (state_r != ST_START);

    assign burst_air_nxt = tx_end ? burst_added :
                           burst_paid ? duty_pkg::AIR_ZERO : burst_air_r;

    // Allowance used up while pause is still owed
    wire burst_spent_after = (burst_added >= allow_r);
    wire pause_left_after = (owed_added != duty_pkg::OWED_ZERO);
    wire must_hold = burst_spent_after && pause_left_after;
    wire burst_spent_now = (burst_air_r >= allow_r) && !owed_zero;

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    wire may_send = pkt_req && !sleep && !burst_spent_now;

    always_comb
    begin
        state_nxt = state_r;
        tx_start_nxt = 1'b0;
        pkt_done_nxt = 1'b0;
        unique case (state_r)
            ST_IDLE:
            begin
                if (burst_spent_now)
                    state_nxt = ST_HOLD;
                else if (may_send)
                begin
                    state_nxt = ST_START;
                    tx_start_nxt = 1'b1;
                end
            end
            ST_START:
            begin
                if (tx_active)
                    state_nxt = ST_TX;
            end
            ST_TX:
            begin
                if (!tx_active)
                begin
                    pkt_done_nxt = 1'b1;
                    state_nxt = must_hold ? ST_HOLD : ST_IDLE;
                end
            end
            ST_HOLD:
            begin
                if (owed_zero)
                    state_nxt = ST_IDLE;
            end
        endcase
    end

    // Hold shows on the output from the first cycle of the wait
    assign tx_hold_nxt = (state_nxt == ST_HOLD);

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    // Reset clears both accumulators and releases any hold
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= ST_IDLE;
            pkt_air_r <= duty_pkg::AIR_ZERO;
            burst_air_r <= duty_pkg::AIR_ZERO;
            owed_r <= duty_pkg::OWED_ZERO;
            allow_r <= duty_pkg::ALLOW_RESET_MS;
            tx_hold_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            pkt_air_r <= pkt_air_nxt;
            burst_air_r <= burst_air_nxt;
            owed_r <= owed_nxt;
            allow_r <= allow_nxt;
            tx_hold_r <= tx_hold_nxt;
        end
    end

    // ------------------------------------------------------------
    // Event outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_start_r <= 1'b0;
            pkt_done_r <= 1'b0;
        end
        else
        begin
            tx_start_r <= tx_start_nxt;
            pkt_done_r <= pkt_done_nxt;
        end
    end

endmodule : tx_duty_cycle_governor
`default_nettype wire

/* File: verif/duty_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module duty_monitor #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic clock, // Clock
    input wire logic reset_n, // Reset
    input wire logic pkt_req, // Request
    input wire logic tx_active, // On air
    input wire logic sleep, // Asleep
    input wire logic allow_load, // Strobe
    input wire logic [duty_pkg::AIR_W-1:0] allow_ms, // Allowance in
    input wire logic radio_load, // Strobe
    input wire logic [6:0] channel, // Channel
    input wire logic [3:0] power_level, // Level
    input wire logic tx_start_r, // Start
    input wire logic pkt_done_r, // Done
    input wire logic tx_hold_r, // Hold
    input wire logic [duty_pkg::AIR_W-1:0] allow_r, // Allowance
    input wire logic [duty_pkg::AIR_W-1:0] burst_air_r, // Burst
    input wire logic [duty_pkg::OWED_W-1:0] owed_r, // Owed
    input wire duty_pkg::radio_cfg_t radio_cfg_r, // Settings
    input wire logic radio_err_r // Rejected
);
    // ----
    // Load decode
    // ----
    wire logic ch_low;
    wire logic lvl_ok;
    wire logic good_load;
    assign ch_low = channel >= 7'h01 && channel <= 7'h0A;
    assign lvl_ok = power_level >= 4'h1 && power_level <= 4'hA;
    assign good_load = radio_load && lvl_ok && (ch_low || channel == 7'h64);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    // ----
    // Checks
    // ----
    a_owed_twelve: assert property (pkt_done_r |-> (int'(owed_r) - int'($past(owed_r))
        - 12 * (int'(burst_air_r) - int'($past(burst_air_r)))) inside {0, -1}) else $error("pause not 12x air");
    a_allow_clamp: assert property (allow_load |=> allow_r == ($past(allow_ms) > 16'h7530 ?
        16'h7530 : $past(allow_ms))) else $error("allowance not clamped");
    a_start_cause: assert property (tx_start_r |-> $past(pkt_req) && !$past(sleep) &&
        !($past(burst_air_r) >= $past(allow_r) && $past(owed_r) != 0)) else $error("start not allowed");
    a_hold_release: assert property ($fell(tx_hold_r) |-> owed_r == 0 && burst_air_r == 0)
        else $error("hold left early");
    a_hold_bounded: assert property (tx_hold_r && owed_r == 0 |-> ##[1:2] !tx_hold_r)
        else $error("hold stuck");
    a_owed_drains: assert property (!pkt_done_r && $past(owed_r) != 0 |->
        owed_r == $past(owed_r) || owed_r == $past(owed_r) - 1) else $error("owed moved badly");
    a_radio_reject: assert property (radio_load && !good_load |=> radio_err_r && $stable(radio_cfg_r))
        else $error("bad load accepted");
    a_low_freq: assert property (good_load && ch_low |=> radio_cfg_r.rate == duty_pkg::RATE_1200 &&
        radio_cfg_r.freq_hz == duty_pkg::FREQ_CH1_HZ + 30'($past(channel) - 7'h01) * 30'h61A8)
        else $error("low channel wrong");
    a_high_chan: assert property (good_load && channel == 7'h64 |=> radio_cfg_r.freq_hz == 30'h33D3E608
        && radio_cfg_r.rate == duty_pkg::RATE_19200) else $error("fast channel wrong");
    a_amp_enable: assert property (good_load |=> !radio_err_r && radio_cfg_r.pa_rx_en == radio_cfg_r.pa_tx_en
        && radio_cfg_r.pa_tx_en == ($past(power_level) >= 4'h6)) else $error("amplifier enable wrong");
    c_hold: cover property ($rose(tx_hold_r));
    c_back: cover property (pkt_done_r ##1 tx_start_r);
    c_fast: cover property (good_load && channel == 7'h64);
    c_sleep: cover property (sleep && owed_r != $past(owed_r));
endmodule : duty_monitor
bind tx_duty_cycle_governor duty_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon_u (.clock(clock), .reset_n(reset_n),
    .pkt_req(pkt_req), .tx_active(tx_active), .sleep(sleep), .allow_load(allow_load), .allow_ms(allow_ms),
    .radio_load(radio_load), .channel(channel), .power_level(power_level), .tx_start_r(tx_start_r),
    .pkt_done_r(pkt_done_r), .tx_hold_r(tx_hold_r), .allow_r(allow_r), .burst_air_r(burst_air_r),
    .owed_r(owed_r), .radio_cfg_r(radio_cfg_r), .radio_err_r(radio_err_r));
`default_nettype wire

/* File: verif/radio_partner.sv */
`timescale 1ns/1ns
`default_nettype none
module radio_partner (
    input wire logic clock, // Clock
    input wire logic reset_n, // Reset
    input wire logic tx_start_r, // Start from governor
    input wire logic [7:0] lag, // Cycles before keying up
    input wire logic [7:0] air, // Cycles on air
    output logic tx_active // Transceiver on air
);
    logic [8:0] cnt_r;
    logic busy_r;
    // Lag lets a slow radio keep the governor waiting
    assign tx_active = busy_r && cnt_r >= {1'b0, lag} && cnt_r < {1'b0, lag} + {1'b0, air};
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_r <= 9'h000;
            busy_r <= 1'b0;
        end
        else if (tx_start_r)
        begin
            cnt_r <= 9'h000;
            busy_r <= 1'b1;
        end
        else if (busy_r)
        begin
            cnt_r <= cnt_r + 9'h001;
            busy_r <= cnt_r < {1'b0, lag} + {1'b0, air};
        end
    end
endmodule : radio_partner
`default_nettype wire

/* File: verif/tx_duty_cycle_governor_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tx_duty_cycle_governor_tb;
    localparam int TK = 4;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic pkt_req = 1'b0;
    logic sleep = 1'b0;
    logic allow_load = 1'b0;
    logic [15:0] allow_ms = 16'h0000;
    logic radio_load = 1'b0;
    logic [6:0] channel = 7'h01;
    logic [3:0] power_level = 4'h1;
    logic [7:0] lag = 8'h01;
    logic [7:0] air = 8'h14;
    wire logic tx_active;
    logic tx_start_r, pkt_done_r, tx_hold_r, radio_err_r;
    logic [15:0] allow_r, burst_air_r, pv_burst;
    logic [20:0] owed_r, pv_owed;
    logic seen_start = 1'b0;
    duty_pkg::radio_cfg_t radio_cfg_r;
    int err_count = 0;
    int compares = 0;
    always #2 clock = ~clock;
    tx_duty_cycle_governor #(.TICK_CYCLES(TK)) dut_u (.clock(clock), .reset_n(reset_n), .pkt_req(pkt_req),
        .tx_active(tx_active), .sleep(sleep), .allow_load(allow_load), .allow_ms(allow_ms),
        .radio_load(radio_load), .channel(channel), .power_level(power_level), .tx_start_r(tx_start_r),
        .pkt_done_r(pkt_done_r), .tx_hold_r(tx_hold_r), .allow_r(allow_r), .burst_air_r(burst_air_r),
        .owed_r(owed_r), .radio_cfg_r(radio_cfg_r), .radio_err_r(radio_err_r));
    radio_partner far_u (.clock(clock), .reset_n(reset_n), .tx_start_r(tx_start_r), .lag(lag), .air(air),
        .tx_active(tx_active));
    // ----
    // Helpers
    // ----
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        if (err_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    task automatic step(input int n);
        repeat (n)
        begin
            pv_owed = owed_r;
            pv_burst = burst_air_r;
            @(posedge clock);
            #1;
            seen_start = seen_start | tx_start_r;
        end
    endtask : step
    // Waits for start, done or hold release; a spent bound ends the run
    task automatic await(input int sel, input int bound, output int n);
        n = 0;
        while (sel == 0 ? tx_start_r !== 1'b1 : sel == 1 ? pkt_done_r !== 1'b1 : tx_hold_r !== 1'b0)
        begin
            if (n == bound)
            begin
                err_count++;
                close_out();
            end
            step(1);
            n++;
        end
    endtask : await
    task automatic load(input logic radio, input logic [15:0] v, input logic [6:0] ch, input logic [3:0] lv);
        allow_ms = v;
        channel = ch;
        power_level = lv;
        radio_load = radio;
        allow_load = !radio;
        step(1);
        radio_load = 1'b0;
        allow_load = 1'b0;
        step(1);
    endtask : load
    task automatic send_pkt(input logic [7:0] a, output int w);
        int n;
        int d;
        air = a;
        pkt_req = 1'b1;
        await(0, 50, w);
        pkt_req = 1'b0;
        await(1, 4 * a + 50, n);
        d = int'(burst_air_r) - int'(pv_burst);
        check(d >= a / TK && d <= a / TK + 2, 1'b1);
        check((int'(owed_r) - int'(pv_owed) - 12 * d) inside {0, -1}, 1'b1);
    endtask : send_pkt
    // ----
    // Scenarios
    // ----
    task automatic reset_check();
        check(allow_r, 16'h7530);
        check({tx_hold_r, radio_err_r, tx_start_r, pkt_done_r, owed_r, burst_air_r}, 41'h0);
        check(radio_cfg_r, {duty_pkg::FREQ_CH1_HZ, duty_pkg::RATE_1200, 5'h0A, 2'b00});
    endtask : reset_check
    task automatic radio_scan();
        logic [4:0] dbm [10] = '{5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h12, 5'h16, 5'h18, 5'h1A, 5'h1B};
        logic [6:0] bad_ch [5] = '{7'h00, 7'h0B, 7'h65, 7'h05, 7'h05};
        logic [3:0] bad_lv [5] = '{4'h1, 4'h1, 4'h1, 4'h0, 4'hB};
        logic [37:0] e;
        for (int i = 1; i <= 10; i++)
        begin
            load(1'b1, 16'h0000, 7'(i), 4'(i));
            e = {duty_pkg::FREQ_CH1_HZ + 30'(i - 1) * 30'h61A8, duty_pkg::RATE_1200, dbm[i - 1], {2{i >= 6}}};
            check({radio_err_r, radio_cfg_r}, {1'b0, e});
        end
        load(1'b1, 16'h0000, 7'h64, 4'hA);
        e = {30'h33D3E608, duty_pkg::RATE_19200, 5'h1B, 2'b11};
        check({radio_err_r, radio_cfg_r}, {1'b0, e});
        for (int i = 0; i < 5; i++)
        begin
            load(1'b1, 16'h0000, bad_ch[i], bad_lv[i]);
            check({radio_err_r, radio_cfg_r}, {1'b1, e});
        end
    endtask : radio_scan
    task automatic allow_test();
        logic [15:0] req [3] = '{16'h9C40, 16'h7531, 16'h7530};
        for (int i = 0; i < 3; i++)
        begin
            load(1'b0, req[i], 7'h01, 4'h1);
            check(allow_r, 16'h7530);
        end
    endtask : allow_test
    task automatic burst_test();
        int w;
        logic [20:0] owed0;
        load(1'b0, 16'h0028, 7'h01, 4'h1);
        check(allow_r, 16'h0028);
        send_pkt(8'h14, w);
        send_pkt(8'h14, w);
        check(w <= 2 && tx_hold_r === 1'b0, 1'b1);
        owed0 = owed_r;
        seen_start = 1'b0;
        sleep = 1'b1;
        pkt_req = 1'b1;
        step(20);
        check({seen_start, owed0 - owed_r inside {4, 5, 6}}, 2'b01);
        sleep = 1'b0;
        lag = 8'h06;
        send_pkt(8'h50, w);
        check(w <= 2, 1'b1);
        send_pkt(8'h50, w);
        check(tx_hold_r, 1'b1);
        owed0 = owed_r;
        seen_start = 1'b0;
        pkt_req = 1'b1;
        await(2, 9000, w);
        check({seen_start, owed_r, burst_air_r}, 38'h0);
        check(w >= (int'(owed0) - 1) * TK, 1'b1);
        await(0, 3, w);
        pkt_req = 1'b0;
        await(1, 400, w);
    endtask : burst_test
    task automatic reset_test();
        load(1'b0, 16'h0002, 7'h01, 4'h1);
        check(tx_hold_r, 1'b1);
        reset_n = 1'b0;
        step(8);
        reset_n = 1'b1;
        step(1);
        reset_check();
    endtask : reset_test
    initial
    begin
        repeat (8) @(posedge clock);
        #1;
        reset_n = 1'b1;
        reset_check();
        radio_scan();
        allow_test();
        burst_test();
        reset_test();
        close_out();
    end
endmodule : tx_duty_cycle_governor_tb
`default_nettype wire
